// >>> verilog/sl_pkg.sv
// shared constants of the serial loader command link
package sl_pkg;
   // command opcodes
   localparam logic [7:0] SL_OP_PING = 8'h20;
   localparam logic [7:0] SL_OP_DOWNLOAD = 8'h21;
   localparam logic [7:0] SL_OP_RUN = 8'h22;
   localparam logic [7:0] SL_OP_QUERY = 8'h23;
   localparam logic [7:0] SL_OP_DATA = 8'h24;
   localparam logic [7:0] SL_OP_RESET = 8'h25;
   // answer bytes
   localparam logic [7:0] SL_ACK = 8'hCC;
   localparam logic [7:0] SL_NAK = 8'h33;
   // packet lengths, size byte included
   localparam logic [7:0] SL_LEN_SHORT = 8'h03;
   localparam logic [7:0] SL_LEN_RUN = 8'h07;
   localparam logic [7:0] SL_LEN_LONG = 8'h0B;
   localparam logic [7:0] SL_HDR_BYTES = 8'h02;
   localparam logic [7:0] SL_OPC_BYTES = 8'h03;
   localparam int SL_MAX_DATA = 8;
   // parameter positions inside the data bytes (opcode at 0)
   localparam int SL_POS_ADDR = 1;
   localparam int SL_POS_LEN = 5;
   // outcome codes returned by the query command
   localparam logic [7:0] SL_ST_OK = 8'h40;
   localparam logic [7:0] SL_ST_UNKNOWN = 8'h41;
   localparam logic [7:0] SL_ST_INVALID = 8'h42;
   localparam logic [7:0] SL_ST_FAIL = 8'h43;
   localparam logic [7:0] SL_ST_RESET = SL_ST_OK;
   // default flash size in bytes
   localparam logic [31:0] SL_FLASH_BYTES = 32'h0000_8000;
endpackage

// >>> verilog/sl_link_if.sv
// byte link between host and loader device
`timescale 1ns/10ps
interface sl_link_if;
   logic h2d_valid;
   logic h2d_ready;
   logic [7:0] h2d_data;
   logic d2h_valid;
   logic d2h_ready;
   logic [7:0] d2h_data;
   modport host (output h2d_valid, input h2d_ready, output h2d_data,
                 input d2h_valid, output d2h_ready, input d2h_data);
   modport dev (input h2d_valid, output h2d_ready, input h2d_data,
                output d2h_valid, input d2h_ready, output d2h_data);
endinterface

// >>> verilog/sl_buf2.sv
// small valid/ready fifo in front of the device receiver
`timescale 1ns/10ps
module sl_buf2
   import sl_pkg::*;
#(
   parameter int W = 8,
   parameter int DEPTH = 2
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [W-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [W-1:0] out_data
);
   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CW = $clog2(DEPTH + 1);

   // pointers wrap naturally, so depth must be a power of two
   if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
      $error("sl_buf2: DEPTH must be a power of two of at least 2");
   end

   typedef struct packed {
      logic [DEPTH-1:0][W-1:0] mem;
      logic [PW-1:0] wp;
      logic [PW-1:0] rp;
      logic [CW-1:0] cnt;
   } sl_buf_t;

   sl_buf_t q;
   sl_buf_t n;
   logic push;
   logic pop;

   // honest full and empty from the fill count
   assign in_ready = (q.cnt != CW'(DEPTH));
   assign out_valid = (q.cnt != '0);
   assign out_data = q.mem[q.rp];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   // next state of pointers and storage
   always_comb begin
      n = q;
      if (push) begin
         n.mem[q.wp] = in_data;
         n.wp = q.wp + 1'b1;
      end
      if (pop) begin
         n.rp = q.rp + 1'b1;
      end
      n.cnt = q.cnt + CW'(push) - CW'(pop);
   end

   // register the whole state
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         q <= '0;
      end else begin
         q <= n;
      end
   end
endmodule // sl_buf2

// >>> verilog/sl_device.sv
// loader device end: packet receiver, command interpreter, flash sequencer
// What this block and sl_host do
// RULE_01: download setup: 0x21, 11 bytes, two MSB-first words
// RULE_02: first word start address, second byte count
// RULE_03: erase whole region before acknowledging setup
// RULE_04: host queries outcome after download setup
// RULE_05: host sends data only after setup or data
// RULE_06: consecutive data packets continue at advanced address
// RULE_07: host carries at most eight data bytes
// RULE_08: programming stops when byte count is reached
// RULE_09: negative answer leaves program address unchanged
// RULE_10: host queries outcome after each data packet
// RULE_11: run: 0x22, 7 bytes, MSB-first address
// RULE_12: acknowledge run before jumping to address
// RULE_13: reset: 0x25, 3 bytes, device restarts
// RULE_14: acknowledge reset before performing it
// RULE_15: reset is full restart with stack fetch
// RULE_16: sum byte adds data bytes modulo 256
// RULE_17: answer 0xCC or 0x33, leading zeros skipped
// RULE_18: query 0x23 returns last command outcome
// RULE_19: bad setup or orphan data: fail, no write
`timescale 1ns/10ps
module sl_device
   import sl_pkg::*;
#(
   parameter logic [31:0] FLASH_BYTES = sl_pkg::SL_FLASH_BYTES,
   parameter int RX_DEPTH = 2
) (
   input wire logic MCLK,
   input wire logic RST_N,
   sl_link_if.dev LINK,
   output logic FLASH_ERASE_REQ,
   output logic [31:0] FLASH_ERASE_ADDR,
   output logic [31:0] FLASH_ERASE_LEN,
   input wire logic FLASH_ERASE_DONE,
   output logic FLASH_WR_VALID,
   input wire logic FLASH_WR_READY,
   output logic [31:0] FLASH_WR_ADDR,
   output logic [7:0] FLASH_WR_DATA,
   output logic RUN_REQ,
   output logic [31:0] RUN_ADDR,
   output logic SYS_RESET_REQ,
   output logic [7:0] LAST_STATUS
);
   if (FLASH_BYTES == 32'h0000_0000) begin : g_chk
      $error("sl_device: FLASH_BYTES must not be zero");
   end

   typedef enum logic [3:0] {
      S_SIZE, S_SUM, S_DATA, S_EXEC, S_ERASE, S_PROG,
      S_ANS, S_STX, S_SWAIT
   } sl_dev_state_t;

   typedef enum logic [1:0] {P_IDLE, P_STAT, P_RUN, P_RST} sl_post_t;

   typedef struct packed {
      sl_dev_state_t st;
      sl_post_t post;
      logic [7:0] len;
      logic [7:0] sum;
      logic [7:0] acc;
      logic [7:0] cnt;
      logic [7:0] tx;
      logic [8:0][7:0] pk;
      logic [31:0] addr;
      logic [31:0] remain;
      logic [31:0] raddr;
      logic armed;
      logic [7:0] stat;
      logic [7:0] pi;
      logic [7:0] pn;
      logic wv;
      logic [31:0] wa;
      logic [7:0] wd;
      logic er;
      logic run;
      logic rst;
   } sl_dev_t;

   sl_dev_t q;
   sl_dev_t n;
   logic rx_valid;
   logic rx_ready;
   logic [7:0] rx_data;

   // one 32-bit parameter from four data bytes, most significant first
   function automatic logic [31:0] word_at(input logic [8:0][7:0] p,
                                           input int i);
      return {p[i], p[i+1], p[i+2], p[i+3]};
   endfunction

   // receive path buffered so a busy interpreter back-pressures the host
   sl_buf2 #(
      .W(8),
      .DEPTH(RX_DEPTH)
   ) u_rxbuf (
      .clk(MCLK),
      .rst_n(RST_N),
      .in_valid(LINK.h2d_valid),
      .in_ready(LINK.h2d_ready),
      .in_data(LINK.h2d_data),
      .out_valid(rx_valid),
      .out_ready(rx_ready),
      .out_data(rx_data)
   );

   // link outputs and user outputs, all data from flops
   assign LINK.d2h_valid = (q.st == S_ANS) || (q.st == S_STX);
   assign LINK.d2h_data = q.tx;
   assign FLASH_ERASE_REQ = q.er;
   assign FLASH_ERASE_ADDR = q.addr;
   assign FLASH_ERASE_LEN = q.remain;
   assign FLASH_WR_VALID = q.wv;
   assign FLASH_WR_ADDR = q.wa;
   assign FLASH_WR_DATA = q.wd;
   assign RUN_REQ = q.run;
   assign RUN_ADDR = q.raddr;
   assign SYS_RESET_REQ = q.rst;
   assign LAST_STATUS = q.stat;

   // interpreter next state
   always_comb begin
      logic [31:0] a;
      logic [31:0] l;
      logic [7:0] nb;
      logic [32:0] top;
      a = word_at(q.pk, SL_POS_ADDR);
      l = word_at(q.pk, SL_POS_LEN);
      nb = q.len - SL_OPC_BYTES;
      top = {1'b0, a} + {1'b0, l};
      n = q;
      n.run = 1'b0;
      n.rst = 1'b0;
      rx_ready = 1'b0;
      case (q.st)
         S_SIZE: begin
            rx_ready = 1'b1;
            // RULE_17: zero fill before a packet
            if (rx_valid && rx_data != 8'h00) begin
               n.acc = 8'h00;
               n.cnt = 8'h00;
               n.len = rx_data;
               n.st = S_SUM;
               // a size the buffer cannot hold is refused at once
               if (rx_data < SL_LEN_SHORT || rx_data > SL_LEN_LONG) begin
                  n.tx = SL_NAK;
                  n.post = P_IDLE;
                  n.st = S_ANS;
               end
            end
         end
         S_SUM: begin
            rx_ready = 1'b1;
            if (rx_valid) begin
               n.sum = rx_data;
               n.st = S_DATA;
            end
         end
         S_DATA: begin
            rx_ready = 1'b1;
            if (rx_valid) begin
               n.pk[q.cnt[3:0]] = rx_data;
               // RULE_16: running modulo-256 sum
               n.acc = q.acc + rx_data;
               n.cnt = q.cnt + 8'd1;
               if (q.cnt + 8'd1 == q.len - SL_HDR_BYTES) begin
                  n.st = S_EXEC;
               end
            end
         end
         S_EXEC: begin
            n.tx = SL_ACK;
            n.post = P_IDLE;
            n.st = S_ANS;
            if (q.acc != q.sum) begin
               // RULE_09: bad packet, address and count kept
               n.tx = SL_NAK;
            end else begin
               case (q.pk[0])
                  SL_OP_PING: begin
                     n.stat = SL_ST_OK;
                     n.armed = 1'b0;
                  end
                  SL_OP_QUERY: begin
                     // RULE_18: report stored outcome
                     n.post = P_STAT;
                  end
                  SL_OP_DOWNLOAD: begin
                     n.armed = 1'b0;
                     n.stat = SL_ST_INVALID;
                     // RULE_01: long packet, two words
                     if (q.len == SL_LEN_LONG && l != 32'h0000_0000 &&
                         top <= {1'b0, FLASH_BYTES}) begin
                        // RULE_02: start address and byte count
                        n.addr = a;
                        n.remain = l;
                        // RULE_03: erase first, answer later
                        n.er = 1'b1;
                        n.st = S_ERASE;
                     end
                  end
                  SL_OP_DATA: begin
                     // RULE_19: no setup, no write
                     if (!q.armed || q.remain == 32'h0000_0000) begin
                        n.stat = SL_ST_FAIL;
                     end else begin
                        // RULE_08: never past the set count
                        if (q.remain < 32'(nb)) begin
                           nb = q.remain[7:0];
                        end
                        n.pi = 8'h00;
                        n.pn = nb;
                        n.st = S_PROG;
                     end
                  end
                  SL_OP_RUN: begin
                     n.armed = 1'b0;
                     n.stat = SL_ST_INVALID;
                     // RULE_11: seven-byte packet, one word
                     if (q.len == SL_LEN_RUN) begin
                        n.raddr = a;
                        n.stat = SL_ST_OK;
                        n.post = P_RUN;
                     end
                  end
                  SL_OP_RESET: begin
                     // RULE_13: restart after the answer
                     n.armed = 1'b0;
                     n.stat = SL_ST_OK;
                     n.post = P_RST;
                  end
                  default: begin
                     n.armed = 1'b0;
                     n.stat = SL_ST_UNKNOWN;
                  end
               endcase
            end
         end
         S_ERASE: begin
            // request held until the flash side reports completion
            if (FLASH_ERASE_DONE) begin
               n.er = 1'b0;
               n.armed = 1'b1;
               n.stat = SL_ST_OK;
               n.st = S_ANS;
            end
         end
         S_PROG: begin
            if (q.pi == q.pn) begin
               // RULE_06: next packet continues here
               n.addr = q.addr + 32'(q.pn);
               n.remain = q.remain - 32'(q.pn);
               // RULE_08: disarm when the count is used up
               n.armed = (q.remain != 32'(q.pn));
               n.stat = SL_ST_OK;
               n.st = S_ANS;
            end else if (!q.wv) begin
               n.wv = 1'b1;
               n.wa = q.addr + 32'(q.pi);
               n.wd = q.pk[q.pi[3:0] + 4'd1];
            end else if (FLASH_WR_READY) begin
               n.wv = 1'b0;
               n.pi = q.pi + 8'd1;
            end
         end
         S_ANS: begin
            if (LINK.d2h_ready) begin
               n.st = S_SIZE;
               case (q.post)
                  P_STAT: begin
                     n.tx = SL_LEN_SHORT;
                     n.cnt = 8'h00;
                     n.st = S_STX;
                  end
                  // RULE_12: jump only after answer taken
                  P_RUN: n.run = 1'b1;
                  // RULE_14: reset only after answer taken
                  // RULE_15: full restart requested outside
                  P_RST: n.rst = 1'b1;
                  default: n.st = S_SIZE;
               endcase
            end
         end
         S_STX: begin
            // size, sum, code; with one data byte the sum is the code
            if (LINK.d2h_ready) begin
               n.tx = q.stat;
               n.cnt = q.cnt + 8'd1;
               if (q.cnt == 8'd2) begin
                  n.st = S_SWAIT;
               end
            end
         end
         S_SWAIT: begin
            rx_ready = 1'b1;
            // RULE_17: first nonzero byte closes the reply
            if (rx_valid && rx_data != 8'h00) begin
               n.st = S_SIZE;
            end
         end
         default: n.st = S_SIZE;
      endcase
   end

   // register the whole state
   always_ff @(posedge MCLK) begin
      if (!RST_N) begin
         q <= '0;
         q.st <= S_SIZE;
         q.post <= P_IDLE;
         q.stat <= SL_ST_RESET;
      end else begin
         q <= n;
      end
   end
endmodule // sl_device

// >>> verilog/sl_host.sv
// loader host end: builds command packets and collects answers
`timescale 1ns/10ps
module sl_host
   import sl_pkg::*;
(
   input wire logic MCLK,
   input wire logic RST_N,
   sl_link_if.host LINK,
   input wire logic CMD_VALID,
   output logic CMD_READY,
   input wire logic [7:0] CMD_OP,
   input wire logic [31:0] CMD_ADDR,
   input wire logic [31:0] CMD_LEN,
   input wire logic [63:0] CMD_DATA,
   input wire logic [3:0] CMD_NBYTES,
   output logic RSP_VALID,
   output logic RSP_ACK,
   output logic RSP_REFUSED,
   output logic RSP_HAS_STATUS,
   output logic [7:0] RSP_STATUS
);
   typedef enum logic [2:0] {
      H_IDLE, H_SEND, H_WACK, H_RLEN, H_RSUM, H_RVAL, H_TACK
   } sl_host_state_t;

   typedef struct packed {
      sl_host_state_t st;
      logic [10:0][7:0] pk;
      logic [7:0] len;
      logic [3:0] idx;
      logic chain;
      logic may_data;
      logic rv;
      logic ack;
      logic refused;
      logic hasst;
      logic [7:0] stat;
   } sl_host_reg_t;

   sl_host_reg_t q;
   sl_host_reg_t n;

   // whole packet with size and sum bytes filled in
   function automatic logic [10:0][7:0] pkt_of(input logic [7:0] op,
      input logic [31:0] a, input logic [31:0] l, input logic [63:0] d,
      input logic [7:0] len);
      logic [10:0][7:0] p;
      logic [7:0] s;
      p = '0;
      s = 8'h00;
      p[0] = len;
      p[2] = op;
      if (op == SL_OP_DATA) begin
         for (int i = 0; i < SL_MAX_DATA; i++) begin
            p[3+i] = d[63-8*i -: 8];
         end
      end else begin
         {p[3], p[4], p[5], p[6]} = a;
         {p[7], p[8], p[9], p[10]} = l;
      end
      // sum over data bytes only, size and sum excluded
      for (int i = 2; i < 11; i++) begin
         if (i < int'(len)) begin
            s = s + p[i];
         end
      end
      p[1] = s;
      return p;
   endfunction

   // packet length for each opcode
   function automatic logic [7:0] len_of(input logic [7:0] op,
                                         input logic [3:0] nb);
      case (op)
         SL_OP_DOWNLOAD: return SL_LEN_LONG;
         SL_OP_RUN: return SL_LEN_RUN;
         SL_OP_DATA: return SL_OPC_BYTES + {4'h0, nb};
         default: return SL_LEN_SHORT;
      endcase
   endfunction

   assign CMD_READY = (q.st == H_IDLE);
   assign LINK.h2d_valid = (q.st == H_SEND) || (q.st == H_TACK);
   assign LINK.h2d_data = (q.st == H_TACK) ? SL_ACK : q.pk[q.idx];
   assign LINK.d2h_ready = (q.st == H_WACK) || (q.st == H_RLEN) ||
                           (q.st == H_RSUM) || (q.st == H_RVAL);
   assign RSP_VALID = q.rv;
   assign RSP_ACK = q.ack;
   assign RSP_REFUSED = q.refused;
   assign RSP_HAS_STATUS = q.hasst;
   assign RSP_STATUS = q.stat;

   // command sequencer
   always_comb begin
      logic [7:0] ln;
      ln = len_of(CMD_OP, CMD_NBYTES);
      n = q;
      n.rv = 1'b0;
      case (q.st)
         H_IDLE: begin
            if (CMD_VALID) begin
               n.refused = 1'b0;
               n.hasst = 1'b0;
               n.ack = 1'b0;
               // RULE_05: data only after setup or data
               // RULE_07: one to eight data bytes
               if (CMD_OP == SL_OP_DATA && (!q.may_data ||
                   CMD_NBYTES == 4'h0 || CMD_NBYTES > 4'(SL_MAX_DATA))) begin
                  n.refused = 1'b1;
                  n.rv = 1'b1;
               end else begin
                  n.pk = pkt_of(CMD_OP, CMD_ADDR, CMD_LEN, CMD_DATA, ln);
                  n.len = ln;
                  n.idx = 4'h0;
                  n.chain = 1'b0;
                  n.st = H_SEND;
               end
            end
         end
         H_SEND: begin
            if (LINK.h2d_ready) begin
               n.idx = q.idx + 4'h1;
               if (8'(q.idx) + 8'd1 == q.len) begin
                  n.st = H_WACK;
               end
            end
         end
         H_WACK: begin
            // zero fill ahead of the answer is skipped
            if (LINK.d2h_valid && LINK.d2h_data != 8'h00) begin
               n.ack = q.chain ? q.ack : (LINK.d2h_data == SL_ACK);
               n.st = H_IDLE;
               n.rv = 1'b1;
               if (LINK.d2h_data != SL_ACK) begin
                  // a refused query still reports the first answer
                  n.ack = q.chain ? q.ack : 1'b0;
               end else if (q.pk[2] == SL_OP_QUERY) begin
                  n.rv = 1'b0;
                  n.st = H_RLEN;
               end else if (q.pk[2] == SL_OP_DOWNLOAD ||
                            q.pk[2] == SL_OP_DATA) begin
                  // RULE_04: outcome query after setup
                  // RULE_10: outcome query after data
                  n.may_data = 1'b1;
                  n.rv = 1'b0;
                  n.chain = 1'b1;
                  n.pk = pkt_of(SL_OP_QUERY, 32'h0000_0000, 32'h0000_0000,
                                64'h0000_0000_0000_0000, SL_LEN_SHORT);
                  n.len = SL_LEN_SHORT;
                  n.idx = 4'h0;
                  n.st = H_SEND;
               end else begin
                  n.may_data = 1'b0;
               end
            end
         end
         H_RLEN: begin
            if (LINK.d2h_valid && LINK.d2h_data != 8'h00) begin
               n.st = H_RSUM;
            end
         end
         H_RSUM: begin
            if (LINK.d2h_valid) begin
               n.st = H_RVAL;
            end
         end
         H_RVAL: begin
            if (LINK.d2h_valid) begin
               n.stat = LINK.d2h_data;
               n.st = H_TACK;
            end
         end
         H_TACK: begin
            if (LINK.h2d_ready) begin
               n.hasst = 1'b1;
               n.ack = q.chain ? q.ack : 1'b1;
               n.rv = 1'b1;
               n.st = H_IDLE;
            end
         end
         default: n.st = H_IDLE;
      endcase
   end

   // register the whole state
   always_ff @(posedge MCLK) begin
      if (!RST_N) begin
         q <= '0;
         q.st <= H_IDLE;
      end else begin
         q <= n;
      end
   end
endmodule // sl_host

// >>> tb/sl_link_chk.sv
// checker on the host/loader byte link and the loader's flash side
`timescale 1ns/10ps
module sl_link_chk
   import sl_pkg::*;
(
   input wire logic MCLK,
   input wire logic RST_N,
   input wire logic h2d_valid,
   input wire logic h2d_ready,
   input wire logic [7:0] h2d_data,
   input wire logic d2h_valid,
   input wire logic d2h_ready,
   input wire logic [7:0] d2h_data,
   input wire logic FLASH_ERASE_REQ,
   input wire logic FLASH_ERASE_DONE,
   input wire logic FLASH_WR_VALID,
   input wire logic FLASH_WR_READY,
   input wire logic [31:0] FLASH_WR_ADDR,
   input wire logic RUN_REQ,
   input wire logic SYS_RESET_REQ
);
   logic [31:0] nxt_q;
   logic armed_q;
   logic [7:0] age_q;
   default clocking cb @(posedge MCLK); endclocking
   default disable iff (!RST_N);
   // next write address, and cycles since an ack byte was taken
   always_ff @(posedge MCLK) begin
      if (!RST_N) begin
         nxt_q <= 32'h0000_0000;
         armed_q <= 1'b0;
         age_q <= 8'hFF;
      end else begin
         if (FLASH_ERASE_REQ) armed_q <= 1'b0;
         else if (FLASH_WR_VALID && FLASH_WR_READY) armed_q <= 1'b1;
         if (FLASH_WR_VALID && FLASH_WR_READY) begin
            nxt_q <= FLASH_WR_ADDR + 32'h0000_0001;
         end
         // saturate so an old ack never looks fresh again
         if (d2h_valid && d2h_ready && d2h_data == SL_ACK) age_q <= 8'h00;
         else if (age_q != 8'hFF) age_q <= age_q + 8'h01;
      end
   end
   a_host_byte_hold: assert property (h2d_valid && !h2d_ready |=>
      h2d_valid && $stable(h2d_data)) else $error("host byte dropped");
   a_dev_byte_hold: assert property (d2h_valid && !d2h_ready |=>
      d2h_valid && $stable(d2h_data)) else $error("device byte dropped");
   a_erase_then_ack: assert property ($fell(FLASH_ERASE_REQ) |->
      d2h_valid && d2h_data == SL_ACK) else $error("no ack after erase");
   a_erase_req_hold: assert property (FLASH_ERASE_REQ
      && !FLASH_ERASE_DONE |=> FLASH_ERASE_REQ)
      else $error("erase request dropped early");
   a_write_hold: assert property (FLASH_WR_VALID && !FLASH_WR_READY
      |=> FLASH_WR_VALID && $stable(FLASH_WR_ADDR))
      else $error("write dropped");
   a_write_addr_step: assert property ($rose(FLASH_WR_VALID)
      && armed_q |-> FLASH_WR_ADDR == nxt_q)
      else $error("write address skipped");
   a_run_after_ack: assert property (RUN_REQ |-> age_q < 8'h10)
      else $error("run without prior ack");
   a_reset_after_ack: assert property (SYS_RESET_REQ
      |-> age_q < 8'h10) else $error("restart without prior ack");
   a_run_pulse_once: assert property (RUN_REQ |=> !RUN_REQ [*2])
      else $error("run request not a single pulse");
endmodule // sl_link_chk

// >>> tb/tb_serial_loader_flash_commands.sv
// bench: host and loader ends joined over the byte link
`timescale 1ns/10ps
module tb_serial_loader_flash_commands;
   import sl_pkg::*;
   logic mclk = 1'b0;
   logic rst_n = 1'b0;
   logic cv = 1'b0, ed = 1'b0, wr = 1'b0, epv = 1'b0;
   logic [7:0] op = 8'h00;
   logic [31:0] ca = 32'h0000_0000, cl = 32'h0000_0000;
   logic [63:0] cd = 64'h0000_0000_0000_0000;
   logic [3:0] cn = 4'h0;
   logic [2:0] cyc = 3'h0;
   logic cr, rv, ra, rf, rh, er, wv, rq, sr;
   logic [7:0] rs, wdat, ls;
   logic [31:0] eadr, elen, wadr, radr, ea, el;
   logic [31:0] wa[$];
   logic [7:0] wd[$];
   int bad_count = 0, checked = 0, erases = 0, runs = 0, resets = 0, k;
   sl_link_if i_sl_link_if();
   sl_host i_sl_host (.MCLK(mclk), .RST_N(rst_n), .LINK(i_sl_link_if),
      .CMD_VALID(cv), .CMD_READY(cr), .CMD_OP(op), .CMD_ADDR(ca),
      .CMD_LEN(cl), .CMD_DATA(cd), .CMD_NBYTES(cn), .RSP_VALID(rv),
      .RSP_ACK(ra), .RSP_REFUSED(rf), .RSP_HAS_STATUS(rh), .RSP_STATUS(rs));
   sl_device i_sl_device (.MCLK(mclk), .RST_N(rst_n), .LINK(i_sl_link_if),
      .FLASH_ERASE_REQ(er), .FLASH_ERASE_ADDR(eadr), .FLASH_ERASE_LEN(elen),
      .FLASH_ERASE_DONE(ed), .FLASH_WR_VALID(wv), .FLASH_WR_READY(wr),
      .FLASH_WR_ADDR(wadr), .FLASH_WR_DATA(wdat), .RUN_REQ(rq),
      .RUN_ADDR(radr), .SYS_RESET_REQ(sr), .LAST_STATUS(ls));
   sl_link_chk i_sl_link_chk (.MCLK(mclk), .RST_N(rst_n),
      .h2d_valid(i_sl_link_if.h2d_valid), .h2d_ready(i_sl_link_if.h2d_ready),
      .h2d_data(i_sl_link_if.h2d_data), .d2h_valid(i_sl_link_if.d2h_valid),
      .d2h_ready(i_sl_link_if.d2h_ready), .d2h_data(i_sl_link_if.d2h_data),
      .FLASH_ERASE_REQ(er), .FLASH_ERASE_DONE(ed), .FLASH_WR_VALID(wv),
      .FLASH_WR_READY(wr), .FLASH_WR_ADDR(wadr), .RUN_REQ(rq),
      .SYS_RESET_REQ(sr));
   always #25 mclk = ~mclk;
   // flash stand-in: slow erase, writes stalled on alternate pairs
   always @(negedge mclk) begin
      cyc <= cyc + 3'h1;
      ed <= er && (cyc == 3'h7);
      wr <= wv && cyc[1];
   end
   // record flash traffic and the one-cycle requests
   always @(posedge mclk) begin
      if (rst_n) begin
         if (wv && wr) begin
            wa.push_back(wadr);
            wd.push_back(wdat);
         end
         if (er && !epv) begin
            erases++;
            ea = eadr;
            el = elen;
         end
         runs += int'(rq);
         resets += int'(sr);
      end
      epv = er;
   end
   task automatic print_verdict;
      if (bad_count == 0 && checked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
      checked++;
      if (seen !== exp) begin
         bad_count++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // one command through the host port, waiting for its response pulse
   task automatic send(input logic [7:0] o, input logic [31:0] a,
         input logic [31:0] l, input logic [63:0] d, input logic [3:0] n);
      int t;
      @(negedge mclk);
      op = o;
      ca = a;
      cl = l;
      cd = d;
      cn = n;
      cv = 1'b1;
      for (t = 0; t < 3000 && cr !== 1'b1; t++) @(negedge mclk);
      @(negedge mclk);
      cv = 1'b0;
      for (t = t; t < 6000 && rv !== 1'b1; t++) @(negedge mclk);
      if (t >= 6000) begin
         bad_count++;
         print_verdict();
      end
   endtask
   initial begin
      repeat (6) @(posedge mclk);
      @(negedge mclk);
      rst_n = 1'b1;
      chk(ls, SL_ST_RESET);
      send(SL_OP_QUERY, 0, 0, 0, 0);
      chk({ra, rh, rs}, {2'b11, SL_ST_RESET});
      // data before any setup never reaches the link
      send(SL_OP_DATA, 0, 0, 64'h0102_0304_0506_0708, 4'h8);
      chk(rf, 1'b1);
      send(SL_OP_PING, 0, 0, 0, 0);
      chk({ra, rh}, 2'b10);
      send(SL_OP_DOWNLOAD, 32'h0000_0100, 32'h0000_000A, 0, 0);
      chk({ra, rh, rs}, {2'b11, SL_ST_OK});
      chk(rh, 1'b1);
      chk(ea, 32'h0000_0100);
      chk(el, 32'h0000_000A);
      // full packet, then one running past the byte count
      send(SL_OP_DATA, 0, 0, 64'h1011_1213_1415_1617, 4'h8);
      chk({ra, rs}, {1'b1, SL_ST_OK});
      chk(rh, 1'b1);
      send(SL_OP_DATA, 0, 0, 64'h2021_2223_0000_0000, 4'h4);
      chk(wa.size(), 10);
      for (k = 0; k < wa.size() && k < 10; k++) begin
         chk(wa[k], 32'h0000_0100 + 32'(k));
         chk(wd[k], 8'(k < 8 ? 8'h10 + k : 8'h18 + k));
      end
      // one byte past the end of flash, then exactly up to it
      send(SL_OP_DOWNLOAD, 32'h0000_7FF8, 32'h0000_0009, 0, 0);
      chk({ra, rs}, {1'b1, SL_ST_INVALID});
      send(SL_OP_DATA, 0, 0, 64'h3132_3334_3536_3738, 4'h8);
      chk(wa.size(), 10);
      chk(erases, 1);
      chk(rs, SL_ST_FAIL);
      send(SL_OP_DOWNLOAD, 32'h0000_7FF8, 32'h0000_0008, 0, 0);
      chk({ra, rs, ea}, {1'b1, SL_ST_OK, 32'h0000_7FF8});
      send(SL_OP_RUN, 32'h1234_5678, 0, 0, 0);
      repeat (10) @(negedge mclk);
      chk({ra, radr}, {1'b1, 32'h1234_5678});
      chk(runs, 1);
      send(SL_OP_RESET, 0, 0, 0, 0);
      repeat (10) @(negedge mclk);
      chk({ra, rh, ls}, {2'b10, SL_ST_OK});
      chk(resets, 1);
      print_verdict();
   end
endmodule // tb_serial_loader_flash_commands
